// File: rtl/cdt_pkg.sv
/*
 * Constants, types and decode functions shared by the fetch, decode and
 * address logic of the 8-bit core.
 * Assumes a byte-wide memory on the far side and big-endian 16-bit words.
 */
package cdt_pkg;

    // ------------------------------------------------------------------
    // vectors and address-error region
    // ------------------------------------------------------------------
    localparam logic [15:0] VEC_RESET = 16'hFFFE;
    localparam logic [15:0] VEC_TRAP = 16'hFFEE;
    localparam logic [15:0] VEC_IRQ = 16'hFFF8;
    localparam logic [2:0] MODE_FETCH_GUARD = 3'h1;
    localparam logic [15:0] GUARD_TOP = 16'h001F;

    // ------------------------------------------------------------------
    // condition code bits, reset values, stacking
    // ------------------------------------------------------------------
    localparam int CCR_H = 5;
    localparam int CCR_I = 4;
    localparam int CCR_N = 3;
    localparam int CCR_Z = 2;
    localparam int CCR_V = 1;
    localparam int CCR_C = 0;
    localparam logic [7:0] CCR_RESET = 8'hD0;
    localparam logic [15:0] SP_RESET = 16'h0000;
    localparam logic [2:0] PUSH_LAST = 3'h6;

    // ------------------------------------------------------------------
    // op-codes the sequencer acts on itself
    // ------------------------------------------------------------------
    localparam logic [7:0] OP_ACC_INDEX_EXCHANGE = 8'h18;
    localparam logic [7:0] OP_DAA = 8'h19;
    localparam logic [7:0] OP_SLP = 8'h1A;
    localparam logic [7:0] OP_BRA = 8'h20;
    localparam logic [7:0] OP_LDS_IMM = 8'h8E;
    localparam logic [7:0] OP_LDX_IMM = 8'hCE;
    localparam logic [3:0] BIT_AND = 4'h1;
    localparam logic [3:0] BIT_OR = 4'h2;
    localparam logic [3:0] BIT_XOR = 4'h5;
    localparam logic [3:0] BIT_TEST = 4'hB;

    typedef enum logic [2:0] {
        AM_IMPLIED = 3'h0,
        AM_ACC = 3'h1,
        AM_IMM = 3'h2,
        AM_DIRECT = 3'h3,
        AM_EXT = 3'h4,
        AM_INDEXED = 3'h5,
        AM_REL = 3'h6
    } cdt_mode_t;

    // memory-immediate bit instructions live at 6x and 7x
    function automatic logic is_bit_op(input logic [7:0] op);
        return (op[7:5] == 3'h3) && (op[3:0] inside {BIT_AND, BIT_OR, BIT_XOR, BIT_TEST});
    endfunction : is_bit_op

    function automatic logic is_imm16(input logic [7:0] op);
        return op inside {8'h83, 8'h8C, 8'h8E, 8'hC3, 8'hCC, 8'hCE};
    endfunction : is_imm16

    function automatic logic opcode_defined(input logic [7:0] op);
        return !(op inside {8'h00, 8'h02, 8'h03, 8'h12, 8'h13, 8'h14, 8'h15, 8'h1C, 8'h1D, 8'h1E,
                            8'h1F, 8'h41, 8'h42, 8'h45, 8'h4B, 8'h4E, 8'h51, 8'h52, 8'h55, 8'h5B,
                            8'h5E, 8'h87, 8'h8F, 8'hC7, 8'hCD, 8'hCF});
    endfunction : opcode_defined

    function automatic cdt_mode_t addr_mode(input logic [7:0] op);
        cdt_mode_t m;
        m = AM_IMPLIED;
        case (op[7:4])
            4'h2: m = AM_REL;
            4'h4, 4'h5: m = AM_ACC;
            4'h6, 4'hA, 4'hE: m = AM_INDEXED;
            4'h7: m = is_bit_op(op) ? AM_DIRECT : AM_EXT;
            4'h8, 4'hC: m = (op == 8'h8D) ? AM_REL : AM_IMM;
            4'h9, 4'hD: m = AM_DIRECT;
            4'hB, 4'hF: m = AM_EXT;
            default: m = AM_IMPLIED;
        endcase
        return m;
    endfunction : addr_mode

    function automatic logic [1:0] instr_len(input logic [7:0] op);
        logic [1:0] n;
        n = 2'h2;
        case (addr_mode(op))
            AM_IMPLIED, AM_ACC: n = 2'h1;
            AM_EXT: n = 2'h3;
            AM_IMM: n = is_imm16(op) ? 2'h3 : 2'h2;
            default: n = is_bit_op(op) ? 2'h3 : 2'h2;
        endcase
        return n;
    endfunction : instr_len

    function automatic logic fetch_guarded(input logic [2:0] mode, input logic [15:0] addr);
        return (mode == MODE_FETCH_GUARD) && (addr <= GUARD_TOP);
    endfunction : fetch_guarded

endpackage : cdt_pkg

// File: rtl/cdt_ea_calc.sv
/*
 * Effective-address adder for direct, extended, indexed and relative modes.
 * Assumes operand bytes and registers are stable while the result is used.
 */
`timescale 1ns/1ps
`default_nettype none

module cdt_ea_calc
    import cdt_pkg::*;
(
    input wire cdt_mode_t mode_in,
    input wire logic bit_op_in,
    input wire logic [7:0] byte2_in,
    input wire logic [7:0] byte3_in,
    input wire logic [15:0] index_in,
    input wire logic [15:0] pc_next_in,
    output logic [15:0] ea_out
);

    // ------------------------------------------------------------------
    // address forming
    // ------------------------------------------------------------------
    logic [7:0] offset;

    // bit instructions carry the mask first, so their offset is byte three
    assign offset = bit_op_in ? byte3_in : byte2_in;

    always_comb begin
        case (mode_in)
            AM_DIRECT: ea_out = {8'h00, offset};
            AM_EXT: ea_out = {byte2_in, byte3_in};
            // unsigned offset, carry rippling into the high byte
            AM_INDEXED: ea_out = index_in + {8'h00, offset};
            // sign extension gives the borrow into the high byte
            AM_REL: ea_out = pc_next_in + {{8{byte2_in[7]}}, byte2_in};
            default: ea_out = 16'h0000;
        endcase
    end

endmodule : cdt_ea_calc
`default_nettype wire

// File: rtl/cdt_core_front.sv
/*
 * Fetch, decode, effective address, trap and standby sequencer of the core.
 * Assumes a byte memory that returns read data combinationally during the
 * cycle mem_rd_out is high and takes a write on the edge ending a
 * mem_wr_out cycle; irq_req_in comes from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module cdt_core_front
    import cdt_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic standby_request_n_in,
    input wire logic [2:0] mode_in,
    input wire logic irq_req_in,
    input wire logic [7:0] mem_rdata_in,
    output logic [15:0] mem_addr_out,
    output logic mem_rd_out,
    output logic mem_wr_out,
    output logic mem_fetch_out,
    output logic [7:0] mem_wdata_out,
    output logic dec_valid_out,
    output logic [7:0] dec_opcode_out,
    output cdt_mode_t dec_mode_out,
    output logic [15:0] dec_ea_out,
    output logic [15:0] dec_operand_out,
    output logic selected_accumulator_out,
    output logic trap_out,
    output logic sleep_out,
    output logic standby_out,
    output logic [15:0] acc_d_out,
    output logic [15:0] index_out,
    output logic [15:0] stack_out,
    output logic [7:0] ccr_out
);

    typedef enum logic [3:0] {
        ST_RESET = 4'b0000,
        ST_VEC_HI = 4'b0001,
        ST_VEC_LO = 4'b0011,
        ST_FETCH = 4'b0010,
        ST_OPER1 = 4'b0110,
        ST_OPER2 = 4'b0111,
        ST_EXEC = 4'b0101,
        ST_RMW_RD = 4'b0100,
        ST_RMW_WR = 4'b1100,
        ST_PUSH = 4'b1101,
        ST_SLEEP = 4'b1111
    } cdt_state_t;

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [2:0] standby_request_n_sync;
    logic [2:0] mode_s1, mode_s2, mode_s3, mode_fill;
    logic standby;
    logic [2:0] mode;

    // three stages; a change counts only once stages two and three agree
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            standby_request_n_sync <= 3'h7;
            mode_s1 <= 3'h0;
            mode_s2 <= 3'h0;
            mode_s3 <= 3'h0;
            mode_fill <= 3'h0;
        end else begin
            standby_request_n_sync <= {standby_request_n_sync[1:0], standby_request_n_in};
            mode_s1 <= mode_in;
            mode_s2 <= mode_s1;
            mode_s3 <= mode_s2;
            mode_fill <= {mode_fill[1:0], 1'b1}; // stage three holds a real pin sample once full
        end
    end

    // standby follows the pin level only; nothing else releases it
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            standby <= 1'b0;
        end else if (standby_request_n_sync[1] == standby_request_n_sync[2]) begin
            standby <= ~standby_request_n_sync[2];
        end
    end

    // ------------------------------------------------------------------
    // sequencer state and working registers
    // ------------------------------------------------------------------
    cdt_state_t state;
    logic ph;
    logic [2:0] push_cnt;
    logic [15:0] pc, fetch_pc, ret_pc, vec, ea_tmp;
    logic [7:0] op, b2, b3, acc_a, acc_b, ccr, rmw_res;
    logic [15:0] idx, sp;
    logic [15:0] ea;
    logic [7:0] bit_res;
    logic [7:0] daa_res;
    logic daa_carry;
    logic fetch_err;
    cdt_mode_t cur_mode;

    assign cur_mode = addr_mode(op);

    cdt_ea_calc u_ea (
        .mode_in(cur_mode),
        .bit_op_in(is_bit_op(op)),
        .byte2_in(b2),
        .byte3_in(b3),
        .index_in(idx),
        .pc_next_in(pc),
        .ea_out(ea)
    );

    // a fetch fault is either cause; both together still give one trap
    assign fetch_err = fetch_guarded(mode, fetch_pc) || !opcode_defined(mem_rdata_in);

    // memory-immediate logic on the byte just read back
    always_comb begin
        case (op[3:0])
            BIT_AND, BIT_TEST: bit_res = mem_rdata_in & b2;
            BIT_OR: bit_res = mem_rdata_in | b2;
            BIT_XOR: bit_res = mem_rdata_in ^ b2;
            default: bit_res = mem_rdata_in;
        endcase
    end

    // packed BCD correction of A using the half-carry and carry flags
    always_comb begin
        logic [7:0] corr;
        corr = 8'h00;
        if (ccr[CCR_H] || (acc_a[3:0] > 4'h9)) begin
            corr[3:0] = 4'h6;
        end
        daa_carry = ccr[CCR_C] || (acc_a[7:4] > 4'h9) || ((acc_a[7:4] > 4'h8) && (acc_a[3:0] > 4'h9));
        if (daa_carry) begin
            corr[7:4] = 4'h6;
        end
        daa_res = acc_a + corr;
    end

    // ------------------------------------------------------------------
    // main sequencer
    // ------------------------------------------------------------------
    // every bus state uses two phases per bus byte: issue, then capture or release; reset, execute and sleep take no phases
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            state <= ST_RESET;
            ph <= 1'b0;
            push_cnt <= 3'h0;
            mode <= 3'h0;
            pc <= 16'h0000;
            fetch_pc <= 16'h0000;
            ret_pc <= 16'h0000;
            vec <= VEC_RESET;
            ea_tmp <= 16'h0000;
            op <= 8'h01;
            b2 <= 8'h00;
            b3 <= 8'h00;
            acc_a <= 8'h00;
            acc_b <= 8'h00;
            idx <= 16'h0000;
            sp <= SP_RESET;
            ccr <= CCR_RESET;
            rmw_res <= 8'h00;
            mem_addr_out <= 16'h0000;
            mem_rd_out <= 1'b0;
            mem_wr_out <= 1'b0;
            mem_fetch_out <= 1'b0;
            mem_wdata_out <= 8'h00;
            dec_valid_out <= 1'b0;
            dec_opcode_out <= 8'h00;
            dec_mode_out <= AM_IMPLIED;
            dec_ea_out <= 16'h0000;
            dec_operand_out <= 16'h0000;
            selected_accumulator_out <= 1'b0;
            trap_out <= 1'b0;
            sleep_out <= 1'b0;
        end else if (standby || (standby_request_n_sync[2:1] == 2'b00)) begin // strobes stop as standby_out rises
            // held in the reset state; no write strobe so memory is kept
            state <= ST_RESET;
            ph <= 1'b0;
            ccr <= CCR_RESET;
            mem_rd_out <= 1'b0;
            mem_wr_out <= 1'b0;
            mem_fetch_out <= 1'b0;
            dec_valid_out <= 1'b0;
            trap_out <= 1'b0;
            sleep_out <= 1'b0;
        end else begin
            dec_valid_out <= 1'b0;
            trap_out <= 1'b0;
            case (state)
                ST_RESET: begin
                    if (mode_fill[2] && (mode_s2 == mode_s3)) begin // reset values are no strap reading
                        mode <= mode_s3;
                        vec <= VEC_RESET;
                        state <= ST_VEC_HI;
                    end
                end
                ST_VEC_HI, ST_VEC_LO: begin
                    if (!ph) begin
                        mem_addr_out <= (state == ST_VEC_HI) ? vec : vec + 16'h0001;
                        mem_rd_out <= 1'b1;
                        ph <= 1'b1;
                    end else begin
                        mem_rd_out <= 1'b0;
                        ph <= 1'b0;
                        if (state == ST_VEC_HI) begin
                            pc[15:8] <= mem_rdata_in;
                            state <= ST_VEC_LO;
                        end else begin
                            pc[7:0] <= mem_rdata_in;
                            state <= ST_FETCH;
                        end
                    end
                end
                ST_FETCH: begin
                    if (!ph) begin
                        if (irq_req_in && !ccr[CCR_I]) begin
                            ret_pc <= pc;
                            vec <= VEC_IRQ;
                            push_cnt <= 3'h0;
                            state <= ST_PUSH;
                        end else begin
                            mem_addr_out <= pc;
                            mem_rd_out <= 1'b1;
                            mem_fetch_out <= 1'b1;
                            fetch_pc <= pc;
                            ph <= 1'b1;
                        end
                    end else begin
                        mem_rd_out <= 1'b0;
                        mem_fetch_out <= 1'b0;
                        ph <= 1'b0;
                        op <= mem_rdata_in;
                        // checked only here, never on data cycles; mask ignored
                        if (fetch_err) begin
                            trap_out <= 1'b1;
                            ret_pc <= fetch_pc;
                            vec <= VEC_TRAP;
                            push_cnt <= 3'h0;
                            state <= ST_PUSH;
                        end else begin
                            pc <= pc + 16'h0001;
                            // one-byte forms need no operand fetch
                            state <= (instr_len(mem_rdata_in) == 2'h1) ? ST_EXEC : ST_OPER1;
                        end
                    end
                end
                ST_OPER1, ST_OPER2: begin
                    if (!ph) begin
                        mem_addr_out <= pc;
                        mem_rd_out <= 1'b1;
                        mem_fetch_out <= 1'b1;
                        ph <= 1'b1;
                    end else begin
                        mem_rd_out <= 1'b0;
                        mem_fetch_out <= 1'b0;
                        ph <= 1'b0;
                        pc <= pc + 16'h0001;
                        if (state == ST_OPER1) begin
                            b2 <= mem_rdata_in;
                            state <= (instr_len(op) == 2'h3) ? ST_OPER2 : ST_EXEC;
                        end else begin
                            b3 <= mem_rdata_in;
                            state <= ST_EXEC;
                        end
                    end
                end
                ST_EXEC: begin
                    dec_valid_out <= 1'b1;
                    dec_opcode_out <= op;
                    dec_mode_out <= cur_mode;
                    dec_ea_out <= ea;
                    dec_operand_out <= is_imm16(op) ? {b2, b3} : {8'h00, b2};
                    selected_accumulator_out <= (cur_mode == AM_ACC) ? op[4] : op[6];
                    // the formed address goes to a temporary, index is left alone
                    ea_tmp <= ea;
                    state <= ST_FETCH;
                    if (is_bit_op(op)) begin
                        state <= ST_RMW_RD;
                    end else begin
                        case (op)
                            OP_LDS_IMM: sp <= {b2, b3};
                            OP_LDX_IMM: idx <= {b2, b3};
                            OP_ACC_INDEX_EXCHANGE: begin
                                idx <= {acc_a, acc_b};
                                {acc_a, acc_b} <= idx;
                            end
                            OP_DAA: begin
                                acc_a <= daa_res;
                                ccr[CCR_C] <= daa_carry;
                                ccr[CCR_N] <= daa_res[7];
                                ccr[CCR_Z] <= (daa_res == 8'h00);
                            end
                            OP_SLP: begin
                                sleep_out <= 1'b1;
                                state <= ST_SLEEP;
                            end
                            OP_BRA: pc <= ea;
                            default: state <= ST_FETCH;
                        endcase
                    end
                end
                ST_RMW_RD: begin
                    if (!ph) begin
                        mem_addr_out <= ea_tmp;
                        mem_rd_out <= 1'b1;
                        ph <= 1'b1;
                    end else begin
                        mem_rd_out <= 1'b0;
                        ph <= 1'b0;
                        rmw_res <= bit_res;
                        ccr[CCR_N] <= bit_res[7];
                        ccr[CCR_Z] <= (bit_res == 8'h00);
                        ccr[CCR_V] <= 1'b0;
                        // test only sets flags, memory is not written
                        state <= (op[3:0] == BIT_TEST) ? ST_FETCH : ST_RMW_WR;
                    end
                end
                ST_RMW_WR: begin
                    if (!ph) begin
                        mem_addr_out <= ea_tmp;
                        mem_wdata_out <= rmw_res;
                        mem_wr_out <= 1'b1;
                        ph <= 1'b1;
                    end else begin
                        mem_wr_out <= 1'b0;
                        ph <= 1'b0;
                        state <= ST_FETCH;
                    end
                end
                ST_PUSH: begin
                    // stacks PC, index, A, B, CCR like a normal interrupt
                    if (!ph) begin
                        mem_addr_out <= sp;
                        case (push_cnt)
                            3'h0: mem_wdata_out <= ret_pc[7:0];
                            3'h1: mem_wdata_out <= ret_pc[15:8];
                            3'h2: mem_wdata_out <= idx[7:0];
                            3'h3: mem_wdata_out <= idx[15:8];
                            3'h4: mem_wdata_out <= acc_a;
                            3'h5: mem_wdata_out <= acc_b;
                            default: mem_wdata_out <= ccr;
                        endcase
                        mem_wr_out <= 1'b1;
                        ph <= 1'b1;
                    end else begin
                        mem_wr_out <= 1'b0;
                        ph <= 1'b0;
                        sp <= sp - 16'h0001;
                        push_cnt <= push_cnt + 3'h1;
                        if (push_cnt == PUSH_LAST) begin
                            ccr[CCR_I] <= 1'b1;
                            state <= ST_VEC_HI;
                        end
                    end
                end
                ST_SLEEP: begin
                    // any request wakes; a masked one just resumes fetching
                    if (irq_req_in) begin
                        sleep_out <= 1'b0;
                        state <= ST_FETCH;
                    end
                end
                default: state <= ST_RESET;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // register views
    // ------------------------------------------------------------------
    assign standby_out = standby;
    assign acc_d_out = {acc_a, acc_b};
    assign index_out = idx;
    assign stack_out = sp;
    assign ccr_out = ccr;

endmodule : cdt_core_front
`default_nettype wire

// File: verif/cdt_core_front_asserts.sv
/* checker for the core front end: trap, standby and decode relations
   assumes it is bound to cdt_core_front and sees its ports only */
`timescale 1ns/1ps
`default_nettype none
module cdt_core_front_chk
    import cdt_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic standby_request_n_in,
    input wire logic [15:0] mem_addr_out,
    input wire logic mem_rd_out,
    input wire logic mem_wr_out,
    input wire logic mem_fetch_out,
    input wire logic dec_valid_out,
    input wire logic [7:0] dec_opcode_out,
    input wire logic trap_out,
    input wire logic standby_out
);
    // ----
    // one clock domain, so clocking and reset are stated once
    // ----
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    trap_vector_a: assert property (trap_out |-> ##[8:40] (mem_rd_out && mem_addr_out == VEC_TRAP))
        else $error("trap vector not read");
    trap_on_fetch_a: assert property (trap_out |-> $past(mem_fetch_out))
        else $error("trap without fetch");
    data_no_trap_a: assert property (mem_rd_out && !mem_fetch_out |-> ##2 !trap_out)
        else $error("data read trapped");
    trap_once_a: assert property (trap_out |=> !trap_out [*8])
        else $error("trap taken twice");
    defined_only_a: assert property (dec_valid_out |-> opcode_defined(dec_opcode_out))
        else $error("undefined op decoded");
    standby_entry_a: assert property (!standby_request_n_in [*6] |=> standby_out)
        else $error("standby not entered");
    standby_idle_a: assert property (standby_out |-> !mem_rd_out && !dec_valid_out)
        else $error("activity in standby");
    standby_no_write_a: assert property (standby_out |-> !mem_wr_out)
        else $error("write in standby");
endmodule : cdt_core_front_chk
bind cdt_core_front cdt_core_front_chk chk (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .standby_request_n_in(standby_request_n_in), .mem_addr_out(mem_addr_out), .mem_rd_out(mem_rd_out),
    .mem_wr_out(mem_wr_out), .mem_fetch_out(mem_fetch_out), .dec_valid_out(dec_valid_out),
    .dec_opcode_out(dec_opcode_out), .trap_out(trap_out), .standby_out(standby_out));
`default_nettype wire

// File: verif/cdt_mem_model.sv
/* byte memory on the far side of the core
   assumes the core's one-cycle strobes on one clock */
`timescale 1ns/1ps
`default_nettype none
module cdt_mem_model (
    input wire logic clk_sys_in,
    input wire logic [15:0] addr_in,
    input wire logic rd_in,
    input wire logic wr_in,
    input wire logic [7:0] wdata_in,
    output logic [7:0] rdata_out
);
    // ----
    // storage, loaded by the bench
    // ----
    logic [7:0] mem [65536];
    logic [7:0] junk = 8'h5A;
    // an idle bus shows a moving pattern, so a late sample never matches
    assign rdata_out = rd_in ? mem[addr_in] : junk;
    // write lands on the edge ending the strobe cycle
    always @(posedge clk_sys_in) begin
        junk <= junk + 8'h3B;
        if (wr_in) begin
            mem[addr_in] <= wdata_in;
        end
    end
endmodule : cdt_mem_model
`default_nettype wire

// File: verif/test_cdt_core_front.sv
/* bench for the core front end: decode, trap and standby
   assumes the package, the memory model and the checker are compiled first */
`timescale 1ns/1ps
`default_nettype none
module test_cdt_core_front
    import cdt_pkg::*;
;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic standby_request_n_n = 1'b1;
    logic irq = 1'b0;
    logic [7:0] rdata, wdata, op, ccr;
    logic [15:0] addr, ea, idx, sp, opnd;
    logic rd, wr, fetch, dv, sel, trap, standby_request_n;
    cdt_mode_t mode;
    int num_errors = 0;
    int checks_done = 0;
    logic [15:0] seed = 16'h8AC5; // 35525
    cdt_core_front dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .standby_request_n_in(standby_request_n_n),
        .mode_in(3'h1), .irq_req_in(irq), .mem_rdata_in(rdata), .mem_addr_out(addr), .mem_rd_out(rd),
        .mem_wr_out(wr), .mem_fetch_out(fetch), .mem_wdata_out(wdata), .dec_valid_out(dv), .dec_opcode_out(op),
        .dec_mode_out(mode), .dec_ea_out(ea), .dec_operand_out(opnd), .selected_accumulator_out(sel),
        .trap_out(trap), .sleep_out(), .standby_out(standby_request_n), .acc_d_out(), .index_out(idx), .stack_out(sp),
        .ccr_out(ccr));
    cdt_mem_model mem_i (.clk_sys_in(clk_sys_in), .addr_in(addr), .rd_in(rd), .wr_in(wr), .wdata_in(wdata),
        .rdata_out(rdata));
    // ----
    // helpers
    // ----
    function automatic logic [15:0] rnd();
        seed = seed ^ (seed << 7);
        seed = seed ^ (seed >> 9);
        seed = seed ^ (seed << 8);
        return seed;
    endfunction : rnd
    // unsigned offset with carry into the high byte
    function automatic logic [15:0] idx_ea(input logic [15:0] x, input logic [7:0] o);
        return x + {8'h00, o};
    endfunction : idx_ea
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // bounded wait, sampled after the edge has settled
    task automatic next_dec(input logic [7:0] o, input cdt_mode_t m);
        int n;
        n = 0;
        do begin
            @(posedge clk_sys_in);
            #1;
            n++;
        end while (dv !== 1'b1 && n < 300);
        check("opcode", {8'h00, op}, {8'h00, o});
        check("mode", {13'h0000, mode}, {13'h0000, m});
    endtask : next_dec
    task automatic wait_rd(input logic [15:0] a);
        int n;
        n = 0;
        do begin
            @(posedge clk_sys_in);
            #1;
            n++;
        end while (!(rd === 1'b1 && addr === a) && n < 300);
        check("read address", addr, a);
    endtask : wait_rd
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict
    initial begin
        forever #2.5 clk_sys_in = ~clk_sys_in;
    end
    // the whole run needs well under a thousand cycles
    initial begin
        repeat (4000) @(posedge clk_sys_in);
        num_errors++;
        give_verdict();
    end
    initial begin
        logic [15:0] x, e, r, m;
        logic [7:0] prog [17];
        x = rnd() | 16'h00FF; // low index byte all ones forces a carry
        e = rnd();
        r = rnd() | 16'h0001;
        m = rnd();
        prog = '{8'h8E, 8'h00, 8'h7F, 8'hCE, x[15:8], x[7:0], 8'hB6, e[15:8], e[7:0], 8'hA6, r[7:0],
            8'h71, m[7:0], 8'h05, 8'h5F, 8'h19, 8'h00};
        foreach (prog[i]) mem_i.mem[16'h0100 + 16'(i)] = prog[i];
        mem_i.mem[16'hFFFE] = 8'h01;
        mem_i.mem[16'hFFFF] = 8'h00;
        mem_i.mem[16'hFFEE] = 8'h00;
        mem_i.mem[16'hFFEF] = 8'h10; // trap handler sits in guarded space
        mem_i.mem[16'h0010] = 8'h01; // a defined op, so only its address can trap
        mem_i.mem[16'h0005] = r[15:8];
        repeat (2) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        next_dec(8'h8E, AM_IMM);
        next_dec(8'hCE, AM_IMM);
        check("sp", sp, 16'h007F);
        check("imm16", opnd, x);
        next_dec(8'hB6, AM_EXT);
        check("x", idx, x);
        check("ext ea", ea, e);
        next_dec(8'hA6, AM_INDEXED);
        check("idx ea", ea, idx_ea(x, r[7:0]));
        check("x kept", idx, x);
        next_dec(8'h71, AM_DIRECT);
        check("dir ea", ea, 16'h0005);
        next_dec(8'h5F, AM_ACC);
        check("and", {8'h00, mem_i.mem[16'h0005]}, {8'h00, r[15:8] & m[7:0]});
        check("acc b", {15'h0000, sel}, 16'h0001);
        next_dec(8'h19, AM_IMPLIED);
        check("ccr", {8'h00, ccr}, {8'h00, CCR_RESET | (8'h01 << CCR_Z)});
        $display("decode test done");
        irq <= 1'b1; // a masked request must not outrank the trap
        wait_rd(VEC_TRAP);
        check("pcl", {8'h00, mem_i.mem[16'h007F]}, 16'h0010);
        check("pch", {8'h00, mem_i.mem[16'h007E]}, 16'h0001);
        wait_rd(16'h0010);
        wait_rd(VEC_TRAP);
        $display("trap test done");
        @(posedge clk_sys_in);
        irq <= 1'b0;
        standby_request_n_n <= 1'b0;
        repeat (8) @(posedge clk_sys_in);
        #1;
        check("standby", {15'h0000, standby_request_n}, 16'h0001);
        repeat (20) @(posedge clk_sys_in);
        check("ram", {8'h00, mem_i.mem[16'h0005]}, {8'h00, r[15:8] & m[7:0]});
        standby_request_n_n <= 1'b1;
        wait_rd(VEC_RESET);
        $display("standby test done");
        give_verdict();
    end
endmodule : test_cdt_core_front
`default_nettype wire
